// File: inc/dzc_pkg.sv
// constants for the cpu slowdown and module clock gating block
// Notes on behaviour
// RL1: in slowdown the system clock is untouched and peripherals keep the full-rate clock.
// RL2: setting the slowdown enable bit (bit 11 of the divider register) enters slowdown.
// RL3: the ratio field at bits 14..12 picks 1:1 through 1:128, resetting to 1:1.
// RL4: cpu enables are cut from the peripheral clock so both domains stay aligned.
// RL5: with return-on-interrupt (bit 15) set an interrupt restores full speed, else nothing.
// RL6: a set module-disable bit stops every clock enable to that peripheral.
// RL7: a disabled peripheral has its register access blocked, writes dropped, reads invalid.
// RL8: a peripheral runs only if its disable bit is clear and it is implemented.
// RL9: module-disable bits of present peripherals reset to enabled.
// RL10: setting a disable bit takes effect one instruction cycle later.
// RL11: clearing a disable bit re-enables the peripheral one instruction cycle later.
// RL12: ratio codes 0..7 give cpu divisors 1,2,4,...,128.
// RL13: an interrupt-driven return to full speed clears the slowdown enable bit.
package dzc_pkg;
  localparam int unsigned NUM_MOD = 16;
  localparam logic [31:0] ADDR_CLOCK_DIVIDER_REGISTER = 32'h0000_0000;
  localparam logic [31:0] ADDR_MODDIS = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
  localparam int unsigned BIT_ROI = 15;
  localparam int unsigned BIT_RATIO_HI = 14;
  localparam int unsigned BIT_RATIO_LO = 12;
  localparam int unsigned BIT_SLOW_EN = 11;
  localparam logic [2:0] RATIO_RESET = 3'h0;
  localparam logic [15:0] MODDIS_RESET = 16'h0000;
  localparam logic [15:0] MOD_PRESENT = 16'hFFFF;
  localparam int unsigned DIV_W = 7;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// File: rtl/dzc_clock_ctrl.sv
// cpu slowdown divider and per-module clock enables with wishbone registers
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module dzc_clock_ctrl (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // interrupt request from the interrupt controller
  input wire logic irq_i,
  // clock enables
  output logic cpu_clk_en_o,
  output logic [dzc_pkg::NUM_MOD-1:0] mod_clk_en_o,
  output logic [dzc_pkg::NUM_MOD-1:0] mod_reg_en_o
);
  logic roi_q;
  logic [2:0] ratio_q;
  logic slow_en_q;
  logic [dzc_pkg::NUM_MOD-1:0] moddis_q;
  logic [dzc_pkg::NUM_MOD-1:0] mod_run_q;
  logic [dzc_pkg::DIV_W-1:0] div_cnt_q;
  logic req;
  logic wr_clock_divider_register;
  logic wr_moddis;
  logic irq_return;
  logic div_wrap;
  logic cpu_tick;
  logic [dzc_pkg::DIV_W-1:0] div_mask;

  // divisor 2**code minus one as a counter mask
  function automatic logic [dzc_pkg::DIV_W-1:0] ratio_mask(input logic [2:0] code);
    ratio_mask = dzc_pkg::DIV_W'((8'h01 << code) - 8'h01); // see RL12
  endfunction

  assign req = cyc_i && stb_i && !ack_o;
  assign wr_clock_divider_register = req && we_i && (adr_i == dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER) && sel_i[1];
  assign wr_moddis = req && we_i && (adr_i == dzc_pkg::ADDR_MODDIS);
  assign irq_return = irq_i && roi_q && slow_en_q; // see RL5
  assign div_mask = slow_en_q ? ratio_mask(ratio_q) : '0;
  assign div_wrap = (div_cnt_q & div_mask) == div_mask;
  // enable derives from the same system clock, so cpu and peripheral edges stay aligned
  assign cpu_tick = !slow_en_q || div_wrap; // see RL4

  // wishbone ack: one cycle answer, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (req && !we_i) begin
      case (adr_i)
        dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER: dat_o <= {16'h0000, roi_q, ratio_q, slow_en_q, 11'h000};
        dzc_pkg::ADDR_MODDIS: dat_o <= {16'h0000, moddis_q};
        dzc_pkg::ADDR_STATUS: dat_o <= {16'h0000, mod_run_q};
        default: dat_o <= dzc_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  // divider register fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      roi_q <= 1'b0;
      ratio_q <= dzc_pkg::RATIO_RESET; // see RL3
      slow_en_q <= 1'b0;
    end else begin
      if (wr_clock_divider_register) begin
        roi_q <= dat_i[dzc_pkg::BIT_ROI];
        ratio_q <= dat_i[dzc_pkg::BIT_RATIO_HI:dzc_pkg::BIT_RATIO_LO]; // see RL3
        slow_en_q <= dat_i[dzc_pkg::BIT_SLOW_EN]; // see RL2
      end
      // the interrupt wins over a same-cycle write so a wakeup is never lost
      if (irq_return) begin
        slow_en_q <= 1'b0; // see RL13
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_q <= '0;
    end else if (!slow_en_q || div_wrap) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o <= 1'b1;
    end else begin
      cpu_clk_en_o <= cpu_tick || irq_return; // see RL1
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      moddis_q <= dzc_pkg::MODDIS_RESET; // see RL9
    end else if (wr_moddis) begin
      if (sel_i[0]) moddis_q[7:0] <= dat_i[7:0];
      if (sel_i[1]) moddis_q[15:8] <= dat_i[15:8];
    end
  end

  // one instruction cycle delay: the new bit is applied at the next cpu tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_run_q <= dzc_pkg::MOD_PRESENT & ~dzc_pkg::MODDIS_RESET;
    end else if (cpu_tick) begin
      mod_run_q <= dzc_pkg::MOD_PRESENT & ~moddis_q; // see RL8, RL10, RL11
    end
  end

  // peripheral clocks stay full rate; only the disable gates them
  generate
    for (genvar g = 0; g < dzc_pkg::NUM_MOD; g++) begin : g_mod
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mod_clk_en_o[g] <= dzc_pkg::MOD_PRESENT[g];
          mod_reg_en_o[g] <= dzc_pkg::MOD_PRESENT[g];
        end else begin
          mod_clk_en_o[g] <= mod_run_q[g]; // see RL6, RL1
          mod_reg_en_o[g] <= mod_run_q[g]; // see RL7
        end
      end
    end
  endgenerate

  // check helper: run of cycles with no cpu enable, saturating so it never wraps
  logic [7:0] gap_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_q <= 8'h00;
    end else if (cpu_clk_en_o) begin
      gap_q <= 8'h00;
    end else if (gap_q != 8'hFF) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  // assertions
  sequence s_irq_wake;
    irq_return ##1 !slow_en_q;
  endsequence

  sequence s_read(logic [31:0] a);
    req && !we_i && (adr_i == a) ##1 1'b1;
  endsequence

  sequence s_gate_step(logic dis);
    dis && cpu_tick ##1 1'b1;
  endsequence

  sequence s_phase_start;
    slow_en_q && (ratio_q != dzc_pkg::RATIO_RESET) && !irq_i && (div_cnt_q == '0);
  endsequence

  a_irq_clears_slow: assert property (@(posedge clk_i) disable iff (rst_i) // see RL13
    irq_return |-> ##1 !slow_en_q)
    else $error("slowdown not cleared");
  a_irq_full_speed: assert property (@(posedge clk_i) disable iff (rst_i) // see RL5
    s_irq_wake |-> cpu_clk_en_o)
    else $error("no full speed after irq");
  a_no_roi_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see RL5
    (irq_i && !roi_q && slow_en_q && !wr_clock_divider_register) |=> slow_en_q)
    else $error("irq changed slowdown without roi");
  a_irq_tick: assert property (@(posedge clk_i) disable iff (rst_i) // see RL5
    irq_return |=> cpu_clk_en_o)
    else $error("no cpu enable on wakeup");

  a_full_rate_cpu: assert property (@(posedge clk_i) disable iff (rst_i) // see RL1
    !slow_en_q |=> cpu_clk_en_o)
    else $error("cpu slowed when off");
  a_cnt_idle: assert property (@(posedge clk_i) disable iff (rst_i) // see RL1
    !slow_en_q |=> div_cnt_q == '0)
    else $error("divider runs outside slowdown");
  a_ratio_unity: assert property (@(posedge clk_i) disable iff (rst_i) // see RL3
    (slow_en_q && ratio_q == dzc_pkg::RATIO_RESET) |=> cpu_clk_en_o)
    else $error("1:1 ratio slowed the cpu");

  a_ratio_two: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12
    (slow_en_q && ratio_q == 3'h1 && !irq_i && !wr_clock_divider_register && div_cnt_q == '0)
    |=> ##1 cpu_clk_en_o) else $error("1:2 ratio wrong");
  a_phase_low: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12
    s_phase_start |=> !cpu_clk_en_o)
    else $error("cpu enable at divider start");
  a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12
    (slow_en_q && !div_wrap) |=> div_cnt_q == dzc_pkg::DIV_W'($past(div_cnt_q) + 1'b1))
    else $error("divider did not count");
  a_cnt_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12
    (slow_en_q && div_wrap) |=> div_cnt_q == '0)
    else $error("divider did not wrap");
  a_tick_gap: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12
    gap_q <= {1'b0, {dzc_pkg::DIV_W{1'b1}}})
    else $error("cpu enable gap beyond 1:128");

  a_slow_enter: assert property (@(posedge clk_i) disable iff (rst_i) // see RL2
    (wr_clock_divider_register && dat_i[dzc_pkg::BIT_SLOW_EN] && !irq_return) |=> slow_en_q)
    else $error("slowdown not entered");
  a_slow_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see RL2
    (wr_clock_divider_register && !dat_i[dzc_pkg::BIT_SLOW_EN]) |=> !slow_en_q)
    else $error("slowdown not left");
  a_slow_no_rise: assert property (@(posedge clk_i) disable iff (rst_i) // see RL2
    (!wr_clock_divider_register && !slow_en_q) |=> !slow_en_q)
    else $error("slowdown entered without write");
  a_sel_guard: assert property (@(posedge clk_i) disable iff (rst_i) // see RL2
    (req && we_i && adr_i == dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER && !sel_i[1])
    |=> $stable(ratio_q) && $stable(roi_q)) else $error("masked write landed");

  a_ratio_write: assert property (@(posedge clk_i) disable iff (rst_i) // see RL3
    wr_clock_divider_register |=> ratio_q == $past(dat_i[dzc_pkg::BIT_RATIO_HI:dzc_pkg::BIT_RATIO_LO]))
    else $error("ratio not written");
  a_ratio_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see RL3
    !wr_clock_divider_register |=> $stable(ratio_q))
    else $error("ratio changed without write");
  a_roi_write: assert property (@(posedge clk_i) disable iff (rst_i) // see RL5
    wr_clock_divider_register |=> roi_q == $past(dat_i[dzc_pkg::BIT_ROI]))
    else $error("return bit not written");
  a_roi_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see RL5
    !wr_clock_divider_register |=> $stable(roi_q))
    else $error("return bit changed without write");

  a_disable_late: assert property (@(posedge clk_i) disable iff (rst_i) // see RL11
    $rose(mod_run_q[0]) |=> mod_clk_en_o[0] && mod_reg_en_o[0])
    else $error("module enable not applied");
  a_disable_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see RL6
    (moddis_q[0] && cpu_tick) |=> ##1 !mod_clk_en_o[0])
    else $error("module clock not stopped");
  a_reg_block: assert property (@(posedge clk_i) disable iff (rst_i) // see RL7
    !mod_clk_en_o[1] |-> !mod_reg_en_o[1])
    else $error("registers open");
  a_reg_equal: assert property (@(posedge clk_i) disable iff (rst_i) // see RL7
    mod_reg_en_o == mod_clk_en_o)
    else $error("register and clock enables differ");

  a_moddis_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see RL10
    !wr_moddis |=> $stable(moddis_q))
    else $error("disable bits changed without write");
  a_moddis_low: assert property (@(posedge clk_i) disable iff (rst_i) // see RL6
    (wr_moddis && sel_i[0]) |=> moddis_q[7:0] == $past(dat_i[7:0]))
    else $error("low disable byte not written");
  a_moddis_high: assert property (@(posedge clk_i) disable iff (rst_i) // see RL6
    (wr_moddis && sel_i[1]) |=> moddis_q[15:8] == $past(dat_i[15:8]))
    else $error("high disable byte not written");

  a_run_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see RL10
    !cpu_tick |=> $stable(mod_run_q))
    else $error("module state moved between cpu ticks");
  a_run_follow: assert property (@(posedge clk_i) disable iff (rst_i) // see RL8
    cpu_tick |=> mod_run_q == (dzc_pkg::MOD_PRESENT & ~$past(moddis_q)))
    else $error("module state not taken at cpu tick");
  a_clk_follow: assert property (@(posedge clk_i) disable iff (rst_i) // see RL6
    1'b1 |=> mod_clk_en_o == $past(mod_run_q))
    else $error("module clock does not follow state");
  a_absent_off: assert property (@(posedge clk_i) disable iff (rst_i) // see RL8
    (mod_clk_en_o & ~dzc_pkg::MOD_PRESENT) == '0)
    else $error("absent module clocked");

  generate
    for (genvar m = 0; m < dzc_pkg::NUM_MOD; m++) begin : g_chk
      a_gate_off: assert property (@(posedge clk_i) disable iff (rst_i) // see RL10
        s_gate_step(moddis_q[m]) |=> !mod_clk_en_o[m])
        else $error("module not stopped one cpu cycle later");
      a_gate_on: assert property (@(posedge clk_i) disable iff (rst_i) // see RL11
        s_gate_step(!moddis_q[m] && dzc_pkg::MOD_PRESENT[m]) |=> mod_clk_en_o[m])
        else $error("module not restarted one cpu cycle later");
    end
  endgenerate

  a_read_clock_divider_register: assert property (@(posedge clk_i) disable iff (rst_i) // see RL3
    s_read(dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER) |-> dat_o == {16'h0000, $past(roi_q), $past(ratio_q),
    $past(slow_en_q), 11'h000}) else $error("divider register read wrong");
  a_read_moddis: assert property (@(posedge clk_i) disable iff (rst_i) // see RL9
    s_read(dzc_pkg::ADDR_MODDIS) |-> dat_o == {16'h0000, $past(moddis_q)})
    else $error("disable bits read wrong");
  a_read_status: assert property (@(posedge clk_i) disable iff (rst_i) // see RL8
    s_read(dzc_pkg::ADDR_STATUS) |-> dat_o == {16'h0000, $past(mod_run_q)})
    else $error("status read wrong");
  a_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
    (req && !we_i && adr_i != dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER && adr_i != dzc_pkg::ADDR_MODDIS &&
    adr_i != dzc_pkg::ADDR_STATUS) |=> dat_o == dzc_pkg::UNMAPPED_DATA)
    else $error("unmapped read not zero");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
    ack_o |=> !ack_o)
    else $error("ack held");
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
    req |=> ack_o)
    else $error("request not answered");
  a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
    ack_o |-> $past(req))
    else $error("ack without request");
  a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
    !(cyc_i && stb_i) |=> !ack_o)
    else $error("ack while bus idle");
  a_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
    !(req && !we_i) |=> $stable(dat_o))
    else $error("read data moved without read");
endmodule

// File: testbench/dzc_consumer_model.sv
// cpu core model that counts the clock ticks it is given
`timescale 1ns/1ps
module dzc_consumer_model (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // gated cpu clock enable
  input wire logic cpu_clk_en_i,
  output int cpu_ticks_o
);
  // counts edges only, so a stuck or doubled enable shows as a wrong count
  always_ff @(posedge clk_i) begin
    if (rst_i) cpu_ticks_o <= 0;
    else if (cpu_clk_en_i) cpu_ticks_o <= cpu_ticks_o + 1;
  end
endmodule

// File: testbench/testbench.sv
// random and corner tests of the slowdown and module gating block
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %0t got %h want %h", $time, a, e); end end
module testbench;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, irq_i = 0;
  logic [31:0] adr_i = 0, dat_i = 0, dat_o, rd;
  logic [3:0] sel_i = 4'hF;
  logic ack_o, cpu_clk_en_o;
  logic [15:0] mod_clk_en_o, mod_reg_en_o, mask, lf = 16'h001E;
  int bad_count = 0, samples_checked = 0, cyc_n = 0, t0, ticks;
  initial forever #25 clk_i = ~clk_i;
  // ceiling well above the roughly 2500 cycles the tests need
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  dzc_clock_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .irq_i(irq_i), .cpu_clk_en_o(cpu_clk_en_o),
    .mod_clk_en_o(mod_clk_en_o), .mod_reg_en_o(mod_reg_en_o));
  dzc_consumer_model cpu (.clk_i(clk_i), .rst_i(rst_i), .cpu_clk_en_i(cpu_clk_en_o),
    .cpu_ticks_o(ticks));
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // classic single cycle; the wait is only bounded by the timeout above
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    `CHK(mod_clk_en_o, 16'hFFFF)
    wb(0, dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 0);
    `CHK(rd[15:11], 5'h00)
    wb(0, dzc_pkg::ADDR_MODDIS, 0);
    `CHK(rd, 32'h0000_0000)
    wb(0, 32'h0000_000C, 32'hFFFF_FFFF);
    `CHK(rd, dzc_pkg::UNMAPPED_DATA)
    for (int r = 0; r < 8; r++) begin
      wb(1, dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'h800 | (r << 12));
      repeat (20) @(posedge clk_i);
      t0 = ticks;
      repeat (256) @(posedge clk_i);
      `CHK(ticks - t0, 256 >> r)
      `CHK(mod_clk_en_o, 16'hFFFF)
    end
    for (int k = 0; k < 2; k++) begin
      wb(1, dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'h3800 | (k << 15));
      irq_i <= 1;
      repeat (20) @(posedge clk_i);
      irq_i <= 0;
      wb(0, dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 0);
      `CHK(rd[11], ~k[0])
    end
    `CHK(rd[15:11], 5'h16)
    t0 = ticks;
    repeat (50) @(posedge clk_i);
    `CHK(ticks - t0, 50)
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      mask = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : lf;
      wb(1, dzc_pkg::ADDR_MODDIS, {16'h0000, mask});
      repeat (4) @(posedge clk_i);
      `CHK(mod_clk_en_o, ~mask)
      `CHK(mod_reg_en_o, ~mask)
      wb(0, dzc_pkg::ADDR_STATUS, 0);
      `CHK(rd[15:0], ~mask & dzc_pkg::MOD_PRESENT)
    end
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    `CHK(mod_clk_en_o, 16'hFFFF)
    `CHK(cpu_clk_en_o, 1'b1)
    wb(0, dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 0);
    `CHK(rd, 32'h0000_0000)
    wb(1, dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'h3800);
    wb(1, dzc_pkg::ADDR_MODDIS, {16'h0000, lf});
    repeat (12) @(posedge clk_i);
    `CHK(mod_clk_en_o, ~lf)
    sel_i <= 4'h1;
    wb(1, dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'h7800);
    sel_i <= 4'hF;
    wb(0, dzc_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 0);
    `CHK(rd[15:11], 5'h07)
    complete_run();
  end
endmodule
